// ===== logic/pic_map.svh
// Register indices, field positions, reset values and vector constants of the interrupt controller.
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// Register indices; the APB byte address of a register is four times its index.
`define PIC_IDX_PRIO0 16'hff40
`define PIC_IDX_PRIO1 16'hff42
`define PIC_IDX_PRIO2 16'hff44
`define PIC_IDX_CTRL 16'hff46
`define PIC_IDX_EVSTAT 16'hff48
`define PIC_IDX_EVMASK 16'hff4a
`define PIC_ADDR_W 18
`define PIC_ADDR_LSB 2'b00

// Reset value of every register.
`define PIC_REG_RST 16'h0000

// Priority field low-bit positions (two bits each).
`define PIC_F_SER0 4'd12
`define PIC_F_SER1 4'd8
`define PIC_F_TMR1 4'd0
`define PIC_F_TMR2 4'd12
`define PIC_F_DMA0 4'd8
`define PIC_F_DMA1 4'd4
`define PIC_F_DMA2 4'd12
`define PIC_F_DMA3 4'd8
`define PIC_F_EXT0 4'd4
`define PIC_F_EXT1 4'd0

// Request control bit positions; the upper byte is reserved.
`define PIC_C_DOUBLE 7
`define PIC_C_NMI_VEC 6
`define PIC_C_EXT1_VEC 5
`define PIC_C_EXT0_VEC 4
`define PIC_C_EXT1_MASK 3
`define PIC_C_EXT0_MASK 2
`define PIC_C_EXT1_EDGE 1
`define PIC_C_EXT0_EDGE 0
`define PIC_CTRL_WMASK 16'h00ff

// Event status bits.
`define PIC_EV_NMI 0
`define PIC_EV_EXT0 1
`define PIC_EV_EXT1 2
`define PIC_EV_INT 3
`define PIC_EV_W 4

// Internally generated vectors.
`define PIC_VEC_NMI 8'h31
`define PIC_VEC_EXT0 8'h30
`define PIC_VEC_EXT1 8'h29
`define PIC_VEC_TMR_BASE 8'h42
`define PIC_VEC_DMA_BASE 8'h45
`define PIC_LVL_NMI 3'd7
`define PIC_LVL_NONE 2'd0

// Source counts and candidate positions in fixed tie order.
`define PIC_N_INT 22
`define PIC_N_CAND 24
`define PIC_K_EXT0 5'd22
`define PIC_K_EXT1 5'd23
`define PIC_K_SER 5'd8
`define PIC_SER_SRC 5'd14
`define PIC_TMR_LAST 5'd5

`endif

// ===== logic/pic_pkg.sv
// Types shared by the interrupt controller modules.
package pic_pkg;
  // Acknowledge sequencer states.
  typedef enum logic [1:0] {PIC_IDLE, PIC_ACK1, PIC_ACK2} pic_state_e;
  // Acknowledge mode of the request offered to the processor.
  typedef enum logic [1:0] {PIC_ACK_NONE, PIC_ACK_SINGLE, PIC_ACK_DOUBLE} pic_ack_e;
  typedef logic [1:0] pic_lvl_t;
endpackage

// ===== logic/pic_req_latch.sv
// One external request input: falling-edge pending latch or low-level follower.
`timescale 1ns/1ps
`default_nettype none
module pic_req_latch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin_n,
  input wire logic edge_mode,
  input wire logic clear,
  output logic pending
);
  // Previous pin level; idle is high so reset cannot fake an edge.
  logic prev_r;
  // Pending flag caught on a falling edge.
  logic edge_r;

  ////////////////////////////////////////////////////////////////////////////
  // Edge history.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b1;
    end else if (ce) begin
      prev_r <= pin_n;
    end
  end

  // A new edge in the clearing cycle wins, so no request is lost.
  // Edges are caught only in edge mode, so level-mode history cannot surface later as a request.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_r <= 1'b0;
    end else if (ce) begin
      if (edge_mode && prev_r && !pin_n) begin
        edge_r <= 1'b1;
      end else if (clear) begin
        edge_r <= 1'b0;
      end
    end
  end

  // Level mode simply follows the pin; the source must hold it until served.
  assign pending = edge_mode ? edge_r : !pin_n;
endmodule // pic_req_latch
`default_nettype wire

// ===== logic/pic_top.sv
// Prioritised interrupt controller with APB registers and acknowledge sequencing.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pic_map.svh"
module pic_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PIC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_request_n,
  input wire logic ext_request_0_n,
  input wire logic ext_request_1_n,
  input wire logic [`PIC_N_INT-1:0] int_request,
  input wire logic [2:0] status_mask_level,
  input wire logic cpu_accept,
  input wire logic [31:0] exception_base,
  input wire logic [31:0] next_pc,
  input wire logic [7:0] ext_vector,
  output logic cpu_request,
  output logic [2:0] request_level,
  output pic_pkg::pic_ack_e request_ack_mode,
  output logic ack_strobe,
  output logic vector_valid,
  output logic [7:0] vector_number,
  output logic [31:0] vector_address,
  output logic [2:0] new_mask_level,
  output logic [31:0] saved_pc,
  output logic irq
);
  import pic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [15:0] prio0_r, prio1_r, prio2_r, ctrl_r; // Software priority and control.
  logic [`PIC_EV_W-1:0] ev_stat_r, ev_mask_r; // Sticky events and their mask.
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  logic req_r; // A request is offered to the processor.
  logic [2:0] lvl_r;
  pic_ack_e mode_r;
  logic [4:0] pick_r; // Offered candidate; NMI is flagged apart.
  logic pick_nmi_r;
  logic [7:0] vec_nxt_r; // Internal vector of the offered request.
  pic_state_e state_r;
  logic double_r; // Second acknowledge cycle still owed.
  logic strobe_r, valid_r;
  logic [7:0] vec_r;
  logic [31:0] vaddr_r, pc_r;
  logic [2:0] newmask_r;

  // Bus decode helpers.
  logic setup, wr_go, rd_go;
  logic [15:0] idx;
  logic hit;
  logic [15:0] rd_word;
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready_r && pwrite;
  assign rd_go = psel && penable && pready_r && !pwrite;
  assign idx = paddr[`PIC_ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // External request inputs: NMI is always edge triggered.
  logic [2:0] pin_n, edge_sel, clr, pend;
  logic accept;
  assign accept = ce && cpu_accept && req_r && state_r == PIC_IDLE;
  assign pin_n = {ext_request_1_n, ext_request_0_n, nmi_request_n};
  assign edge_sel = {ctrl_r[`PIC_C_EXT1_EDGE],
                     ctrl_r[`PIC_C_EXT0_EDGE] && !ctrl_r[`PIC_C_DOUBLE], 1'b1};
  assign clr = {accept && !pick_nmi_r && pick_r == `PIC_K_EXT1,
                accept && !pick_nmi_r && pick_r == `PIC_K_EXT0,
                accept && pick_nmi_r};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ext
      pic_req_latch u_latch (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .pin_n(pin_n[g]),
        .edge_mode(edge_sel[g]),
        .clear(clr[g]),
        .pending(pend[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Candidate table in tie order: serial 0, serial 1, timers, DMA, ext 0, ext 1.
  function automatic logic [4:0] src_of(input logic [4:0] k);
    src_of = (k < `PIC_K_SER) ? 5'(k + `PIC_SER_SRC) : 5'(k - `PIC_K_SER);
  endfunction

  // Vector of internal source i; reserved vectors are never produced.
  function automatic logic [7:0] vec_of(input logic [4:0] i);
    vec_of = (i <= `PIC_TMR_LAST) ? 8'(`PIC_VEC_TMR_BASE + i) : 8'(`PIC_VEC_DMA_BASE + i);
  endfunction

  // Two-bit level of internal source i from its unit's field.
  function automatic pic_lvl_t lvl_of(input logic [4:0] i, input logic [15:0] p0,
                                      input logic [15:0] p1, input logic [15:0] p2);
    if (i < 5'd3) lvl_of = pic_lvl_t'(p0 >> `PIC_F_TMR1);
    else if (i < 5'd6) lvl_of = pic_lvl_t'(p1 >> `PIC_F_TMR2);
    else if (i < 5'd8) lvl_of = pic_lvl_t'(p1 >> `PIC_F_DMA0);
    else if (i < 5'd10) lvl_of = pic_lvl_t'(p1 >> `PIC_F_DMA1);
    else if (i < 5'd12) lvl_of = pic_lvl_t'(p2 >> `PIC_F_DMA2);
    else if (i < 5'd14) lvl_of = pic_lvl_t'(p2 >> `PIC_F_DMA3);
    else if (i < 5'd18) lvl_of = pic_lvl_t'(p0 >> `PIC_F_SER0);
    else lvl_of = pic_lvl_t'(p0 >> `PIC_F_SER1);
  endfunction

  logic [`PIC_N_CAND-1:0] c_req;
  pic_lvl_t c_lvl [`PIC_N_CAND];
  generate
    for (g = 0; g < `PIC_N_INT; g++) begin : g_cand
      assign c_req[g] = int_request[src_of(5'(g))];
      assign c_lvl[g] = lvl_of(src_of(5'(g)), prio0_r, prio1_r, prio2_r);
    end
  endgenerate
  assign c_req[`PIC_K_EXT0] = pend[1] && !ctrl_r[`PIC_C_EXT0_MASK];
  assign c_req[`PIC_K_EXT1] = pend[2] && !ctrl_r[`PIC_C_EXT1_MASK];
  assign c_lvl[`PIC_K_EXT0] = pic_lvl_t'(prio2_r >> `PIC_F_EXT0);
  assign c_lvl[`PIC_K_EXT1] = pic_lvl_t'(prio2_r >> `PIC_F_EXT1);

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: highest level wins; on equal level the earlier candidate wins.
  pic_lvl_t best_lvl;
  logic [4:0] best_k;
  always_comb begin
    best_lvl = `PIC_LVL_NONE;
    best_k = 5'd0;
    for (int k = `PIC_N_CAND - 1; k >= 0; k--) begin
      if (c_req[k] && c_lvl[k] != `PIC_LVL_NONE && c_lvl[k] >= best_lvl) begin
        best_lvl = c_lvl[k];
        best_k = 5'(k);
      end
    end
  end

  // Offer only levels above the processor mask; NMI ignores the mask.
  logic offer, offer_nmi;
  assign offer_nmi = pend[0];
  assign offer = offer_nmi || ({1'b0, best_lvl} > status_mask_level);

  // Acknowledge mode of the winner.
  pic_ack_e win_mode;
  always_comb begin
    win_mode = PIC_ACK_NONE;
    if (offer_nmi) begin
      win_mode = ctrl_r[`PIC_C_NMI_VEC] ? PIC_ACK_SINGLE : PIC_ACK_NONE;
    end else if (best_k == `PIC_K_EXT0) begin
      if (ctrl_r[`PIC_C_DOUBLE]) win_mode = PIC_ACK_DOUBLE;
      else if (ctrl_r[`PIC_C_EXT0_VEC]) win_mode = PIC_ACK_SINGLE;
    end else if (best_k == `PIC_K_EXT1) begin
      win_mode = ctrl_r[`PIC_C_EXT1_VEC] ? PIC_ACK_SINGLE : PIC_ACK_NONE;
    end
  end

  // Internal vector of the winner for non-acknowledge service.
  logic [7:0] win_vec;
  always_comb begin
    if (offer_nmi) win_vec = `PIC_VEC_NMI;
    else if (best_k == `PIC_K_EXT0) win_vec = `PIC_VEC_EXT0;
    else if (best_k == `PIC_K_EXT1) win_vec = `PIC_VEC_EXT1;
    else win_vec = vec_of(src_of(best_k));
  end

  // Offer register; held off while an acknowledge sequence runs.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_r <= 1'b0;
      lvl_r <= 3'd0;
      mode_r <= PIC_ACK_NONE;
      pick_r <= 5'd0;
      pick_nmi_r <= 1'b0;
      vec_nxt_r <= 8'h00;
    end else if (ce) begin
      req_r <= offer && state_r == PIC_IDLE && !accept;
      lvl_r <= offer_nmi ? `PIC_LVL_NMI : {1'b0, best_lvl};
      mode_r <= win_mode;
      pick_r <= best_k;
      pick_nmi_r <= offer_nmi;
      vec_nxt_r <= win_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and acknowledge sequencing.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= PIC_IDLE;
      double_r <= 1'b0;
      strobe_r <= 1'b0;
      valid_r <= 1'b0;
      vec_r <= 8'h00;
      vaddr_r <= 32'h0;
      pc_r <= 32'h0;
      newmask_r <= 3'd0;
    end else if (ce) begin
      valid_r <= 1'b0;
      strobe_r <= 1'b0;
      unique case (state_r)
        PIC_IDLE: begin
          if (accept) begin
            newmask_r <= lvl_r;
            pc_r <= next_pc;
            if (mode_r == PIC_ACK_NONE) begin
              vec_r <= vec_nxt_r;
              vaddr_r <= exception_base + {22'h0, vec_nxt_r, 2'b00};
              valid_r <= 1'b1;
            end else begin
              strobe_r <= 1'b1;
              double_r <= mode_r == PIC_ACK_DOUBLE;
              state_r <= PIC_ACK1;
            end
          end
        end
        PIC_ACK1: begin
          if (double_r) begin
            strobe_r <= 1'b1;
            state_r <= PIC_ACK2;
          end else begin
            vec_r <= ext_vector;
            vaddr_r <= exception_base + {22'h0, ext_vector, 2'b00};
            valid_r <= 1'b1;
            state_r <= PIC_IDLE;
          end
        end
        PIC_ACK2: begin
          vec_r <= ext_vector;
          vaddr_r <= exception_base + {22'h0, ext_vector, 2'b00};
          valid_r <= 1'b1;
          double_r <= 1'b0;
          state_r <= PIC_IDLE;
        end
        default: state_r <= PIC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data prepared in the setup cycle.
  always_comb begin
    hit = 1'b1;
    unique case (idx)
      `PIC_IDX_PRIO0: rd_word = prio0_r;
      `PIC_IDX_PRIO1: rd_word = prio1_r;
      `PIC_IDX_PRIO2: rd_word = prio2_r;
      `PIC_IDX_CTRL: rd_word = ctrl_r & `PIC_CTRL_WMASK;
      `PIC_IDX_EVSTAT: rd_word = {12'h0, ev_stat_r};
      `PIC_IDX_EVMASK: rd_word = {12'h0, ev_mask_r};
      default: begin
        rd_word = 16'h0000;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else if (ce) begin
      pready_r <= setup;
      pslverr_r <= setup && (!hit || paddr[1:0] != `PIC_ADDR_LSB);
      if (setup && !pwrite) prdata_r <= {16'h0, rd_word};
    end
  end

  // Register writes; an erroring access changes nothing.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prio0_r <= `PIC_REG_RST;
      prio1_r <= `PIC_REG_RST;
      prio2_r <= `PIC_REG_RST;
      ctrl_r <= `PIC_REG_RST;
      ev_mask_r <= `PIC_EV_W'(`PIC_REG_RST);
    end else if (ce && wr_go && !pslverr_r) begin
      unique case (idx)
        `PIC_IDX_PRIO0: prio0_r <= pwdata[15:0];
        `PIC_IDX_PRIO1: prio1_r <= pwdata[15:0];
        `PIC_IDX_PRIO2: prio2_r <= pwdata[15:0];
        `PIC_IDX_CTRL: ctrl_r <= pwdata[15:0] & `PIC_CTRL_WMASK;
        `PIC_IDX_EVMASK: ev_mask_r <= pwdata[`PIC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Accepted-request events; a read clears only the bits it returned, a same-cycle event wins.
  logic [`PIC_EV_W-1:0] ev_set;
  assign ev_set = {accept && !pick_nmi_r && pick_r < `PIC_K_EXT0,
                   clr[2], clr[1], clr[0]};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_stat_r <= `PIC_EV_W'(`PIC_REG_RST);
      irq_r <= 1'b0;
    end else if (ce) begin
      if (rd_go && !pslverr_r && idx == `PIC_IDX_EVSTAT) ev_stat_r <= ev_set |
          (ev_stat_r & ~prdata_r[`PIC_EV_W-1:0]); // An event at the setup edge survives.
      else ev_stat_r <= ev_stat_r | ev_set;
      irq_r <= |(ev_stat_r & ev_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cpu_request = req_r;
  assign request_level = lvl_r;
  assign request_ack_mode = mode_r;
  assign ack_strobe = strobe_r;
  assign vector_valid = valid_r;
  assign vector_number = vec_r;
  assign vector_address = vaddr_r;
  assign new_mask_level = newmask_r;
  assign saved_pc = pc_r;
  assign irq = irq_r;
endmodule // pic_top
`default_nettype wire

// ===== testbench/pic_top_monitor.sv
// Concurrent checks on the ports of the interrupt controller top.
`timescale 1ns/1ps
`default_nettype none
module pic_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_request,
  input wire logic cpu_accept,
  input wire logic [2:0] request_level,
  input wire pic_pkg::pic_ack_e request_ack_mode,
  input wire logic ack_strobe,
  input wire logic vector_valid,
  input wire logic [7:0] vector_number,
  input wire logic [31:0] vector_address,
  input wire logic [31:0] exception_base,
  input wire logic [31:0] next_pc,
  input wire logic [2:0] new_mask_level,
  input wire logic [31:0] saved_pc
);
  import pic_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // An offer is taken only at an edge where both sides agree.
  logic take;
  assign take = cpu_request && cpu_accept && ce;
  // One acknowledge cycle, then the vector.
  sequence s_single;
    ack_strobe ##1 vector_valid;
  endsequence
  // Two acknowledge cycles back to back, then the vector.
  sequence s_double;
    ack_strobe [*2] ##1 vector_valid;
  endsequence
  a_apb_zero_wait: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_offer_drops: assert property (take |=> !cpu_request)
    else $error("offer held after accept");
  a_mask_level_copy: assert property (take |=> new_mask_level == $past(request_level))
    else $error("accepted level not copied");
  a_return_pc_kept: assert property (take |=> saved_pc == $past(next_pc))
    else $error("return address not captured");
  a_no_ack_vector: assert property (take && request_ack_mode == PIC_ACK_NONE |=>
    vector_valid && !ack_strobe) else $error("internal vector late");
  a_single_ack_seq: assert property (take && request_ack_mode == PIC_ACK_SINGLE |=> s_single)
    else $error("single acknowledge wrong");
  a_double_ack_seq: assert property (take && request_ack_mode == PIC_ACK_DOUBLE |=> s_double)
    else $error("double acknowledge wrong");
  a_table_offset: assert property (vector_valid |->
    vector_address == exception_base + {22'h0, vector_number, 2'b00})
    else $error("table address wrong");
endmodule // pic_chk
bind pic_top pic_chk i_chk (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .cpu_request(cpu_request),
  .cpu_accept(cpu_accept), .request_level(request_level), .request_ack_mode(request_ack_mode),
  .ack_strobe(ack_strobe), .vector_valid(vector_valid), .vector_number(vector_number),
  .vector_address(vector_address), .exception_base(exception_base), .next_pc(next_pc),
  .new_mask_level(new_mask_level), .saved_pc(saved_pc));
`default_nettype wire

// ===== testbench/pic_cpu_model.sv
// Behavioural processor core and external vector source facing the controller.
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cpu_request,
  input wire logic ack_strobe,
  input wire logic [3:0] delay,
  input wire logic [7:0] ack_vec,
  output logic cpu_accept,
  output logic [7:0] ext_vector
);
  logic [3:0] wait_r; // Cycles the current offer has stood.
  // Accept once the offer has stood for the chosen delay, so both prompt and slow cores occur.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 4'h0;
      cpu_accept <= 1'b0;
    end else if (cpu_request && !cpu_accept && wait_r >= delay) begin
      wait_r <= 4'h0;
      cpu_accept <= 1'b1;
    end else begin
      wait_r <= cpu_request ? wait_r + 4'h1 : 4'h0;
      cpu_accept <= 1'b0;
    end
  end
  // Outside acknowledge cycles the bus is released, so show the inverse, never the vector.
  assign ext_vector = ack_strobe ? ack_vec : ~ack_vec;
endmodule // pic_cpu_model
`default_nettype wire

// ===== testbench/pic_top_tb.sv
// Self-checking testbench of the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
`include "pic_map.svh"
module pic_top_tb;
  import pic_pkg::*;
  localparam logic [17:0] A_P0 = {`PIC_IDX_PRIO0, 2'b00};
  localparam logic [17:0] A_P1 = {`PIC_IDX_PRIO1, 2'b00};
  localparam logic [17:0] A_P2 = {`PIC_IDX_PRIO2, 2'b00};
  localparam logic [17:0] A_CT = {`PIC_IDX_CTRL, 2'b00};
  localparam logic [17:0] A_ST = {`PIC_IDX_EVSTAT, 2'b00};
  localparam logic [17:0] A_MK = {`PIC_IDX_EVMASK, 2'b00};
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, exception_base = 32'h0, next_pc = 32'h0;
  logic [31:0] prdata, vector_address, saved_pc;
  logic nmi_request_n = 1'b1, ext_request_0_n = 1'b1, ext_request_1_n = 1'b1;
  logic [21:0] int_request = 22'h0;
  logic [2:0] status_mask_level = 3'h0, request_level, new_mask_level, lv;
  logic [7:0] ext_vector, vector_number, ack_vec = 8'h0;
  logic [3:0] delay = 4'h0;
  logic pready, pslverr, cpu_accept, cpu_request, ack_strobe, vector_valid, irq, e;
  logic [15:0] r, d;
  logic [21:0] f;
  pic_ack_e request_ack_mode;
  logic [31:0] seed = 32'd4715;
  int mismatches = 0, check_count = 0, cycles = 0;
  logic [17:0] ra [4] = '{A_P0, A_P1, A_P2, A_CT};
  logic [15:0] rm [4] = '{16'h3303, 16'h3330, 16'h3333, 16'h00ff}; // Implemented bits.

  pic_top i_dut (.core_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .nmi_request_n, .ext_request_0_n, .ext_request_1_n, .int_request,
    .status_mask_level, .cpu_accept, .exception_base, .next_pc, .ext_vector, .cpu_request,
    .request_level, .request_ack_mode, .ack_strobe, .vector_valid, .vector_number,
    .vector_address, .new_mask_level, .saved_pc, .irq);
  pic_cpu_model i_cpu (.core_clk, .rst, .cpu_request, .ack_strobe, .delay, .ack_vec,
    .cpu_accept, .ext_vector);

  ////////////////////////////////////////////////////////////////////////////////////////////
  always #2 core_clk = ~core_clk;
  // A hang counts as a failure and ends the run.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Vector of internal source i; the reserved numbers are skipped.
  function automatic logic [7:0] vec(input int i);
    return (i < 6) ? 8'(66 + i) : 8'(69 + i);
  endfunction
  // Register address and field shift of internal source i.
  function automatic logic [21:0] fld(input int i);
    case (i)
      0, 1, 2: return {A_P0, 4'd0};
      3, 4, 5: return {A_P1, 4'd12};
      6, 7: return {A_P1, 4'd8};
      8, 9: return {A_P1, 4'd4};
      10, 11: return {A_P2, 4'd12};
      12, 13: return {A_P2, 4'd8};
      14, 15, 16, 17: return {A_P0, 4'd12};
      default: return {A_P0, 4'd8};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [17:0] a, input logic [15:0] wd,
                     output logic [15:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] wd);
    apb(1'b1, a, wd, r, e);
    check(e, 1'b0);
  endtask
  task automatic rdc(input logic [17:0] a, input logic [15:0] exp, input logic [15:0] m);
    apb(1'b0, a, 16'h0, r, e);
    check(r & m, exp & m);
  endtask
  task automatic quiet();
    repeat (8) @(negedge core_clk);
    check(cpu_request, 1'b0);
    // End on a rising edge so that the caller drives its next stimulus there.
    @(posedge core_clk);
  endtask
  // Wait for the core to take an offer, release all sources, then check the vector.
  task automatic take_vec(input logic [7:0] ev, input logic [2:0] el);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(cpu_request === 1'b1 && cpu_accept === 1'b1) && n < 60);
    check(n < 60, 1'b1);
    @(posedge core_clk);
    int_request <= 22'h0;
    {nmi_request_n, ext_request_0_n, ext_request_1_n} <= 3'b111;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (vector_valid !== 1'b1 && n < 20);
    check(vector_valid, 1'b1);
    check(vector_number, ev);
    check(vector_address, exception_base + {22'h0, ev, 2'b00});
    check(new_mask_level, el);
    // End on a rising edge so that the caller drives its next stimulus there.
    @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    exception_base <= rnd();
    for (int k = 0; k < 4; k++) rdc(ra[k], 16'h0, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      d = 16'(rnd());
      wr(ra[k], d);
      rdc(ra[k], d, rm[k]);
      wr(ra[k], 16'h0);
    end
    apb(1'b0, 18'h3fd30, 16'h0, r, e);
    check(e, 1'b1);
    // A misaligned write is refused and leaves the register untouched.
    apb(1'b1, A_P0 | 18'h1, 16'hffff, r, e);
    check(e, 1'b1);
    rdc(A_P0, 16'h0, 16'hffff);
    $display("registers done");
    // Each internal source: masked first, then at a random level.
    wr(A_MK, 16'h0008);
    for (int i = 0; i < 22; i++) begin
      lv = 3'(rnd() % 3 + 1);
      f = fld(i);
      int_request <= 22'h1 << i;
      quiet();
      delay <= 4'(rnd());
      next_pc <= rnd();
      wr(f[21:4], 16'(lv) << f[3:0]);
      take_vec(vec(i), lv);
      wr(f[21:4], 16'h0);
    end
    check(irq, 1'b1);
    rdc(A_ST, 16'h0008, 16'hffff);
    repeat (2) @(negedge core_clk);
    check(irq, 1'b0);
    wr(A_MK, 16'h0000);
    $display("internal sources done");
    wr(A_P0, 16'h2002);
    int_request <= 22'h04001;
    take_vec(8'd83, 3'd2);
    wr(A_P0, 16'h1003);
    int_request <= 22'h04001;
    take_vec(8'd66, 3'd3);
    wr(A_P2, 16'h0011);
    {ext_request_0_n, ext_request_1_n} <= 2'b00;
    take_vec(`PIC_VEC_EXT0, 3'd1);
    status_mask_level <= 3'd3;
    int_request <= 22'h1;
    quiet();
    nmi_request_n <= 1'b0;
    @(posedge core_clk);
    nmi_request_n <= 1'b1;
    take_vec(`PIC_VEC_NMI, 3'd7);
    status_mask_level <= 3'd0;
    $display("priority done");
    wr(A_P2, 16'h0033);
    wr(A_CT, 16'h0004);
    ext_request_0_n <= 1'b0;
    quiet();
    ext_request_1_n <= 1'b0;
    take_vec(`PIC_VEC_EXT1, 3'd3);
    wr(A_CT, 16'h0002);
    ext_request_1_n <= 1'b0;
    @(posedge core_clk);
    ext_request_1_n <= 1'b1;
    take_vec(`PIC_VEC_EXT1, 3'd3);
    quiet();
    // With the clock enable low the edge must not be seen until the block runs again.
    ce <= 1'b0;
    ext_request_1_n <= 1'b0;
    quiet();
    ce <= 1'b1;
    take_vec(`PIC_VEC_EXT1, 3'd3);
    ack_vec <= 8'(rnd());
    wr(A_CT, 16'h0020);
    ext_request_1_n <= 1'b0;
    take_vec(ack_vec, 3'd3);
    // The non-maskable input in external vector mode takes one acknowledge cycle.
    wr(A_CT, 16'h0040);
    nmi_request_n <= 1'b0;
    @(posedge core_clk);
    nmi_request_n <= 1'b1;
    take_vec(ack_vec, 3'd7);
    wr(A_CT, 16'h0080);
    ext_request_0_n <= 1'b0;
    take_vec(ack_vec, 3'd3);
    check(irq, 1'b0);
    // Every kind of accepted request has left its sticky bit since the last status read.
    rdc(A_ST, 16'h000f, 16'hffff);
    $display("external modes done");
    report_and_stop();
  end
endmodule // pic_top_tb
`default_nettype wire
